//--- rtl/insn_exec_pkg.sv
package insn_exec_pkg;

	// datapath widths
	localparam int DATA_W     = 8;
	localparam int FILE_AW    = 7;
	localparam int FILE_DEPTH = 128;
	localparam int OPC_W      = 14;
	localparam int PC_WIDTH   = 13;
	localparam int APB_AW     = 12;

	// instruction cycle timing at a 5 ns core clock
	localparam int CLK_PERIOD_NS        = 5;
	localparam int INSN_CYCLE_NS        = 20;
	localparam int INSN_CYCLE_CLKS_DFLT = (INSN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] CYCLES_RET = 2'h2;
	localparam logic [1:0] CYCLES_ONE = 2'h1;

	// register byte offsets
	localparam logic [APB_AW-1:0] ADDR_INSN      = 12'h000;
	localparam logic [APB_AW-1:0] ADDR_STATUS    = 12'h004;
	localparam logic [APB_AW-1:0] ADDR_ACC       = 12'h008;
	localparam logic [APB_AW-1:0] ADDR_PC        = 12'h00C;
	localparam logic [APB_AW-1:0] ADDR_FILE_ADDR = 12'h010;
	localparam logic [APB_AW-1:0] ADDR_FILE_DATA = 12'h014;

	// status register bit positions
	localparam int ST_BUSY  = 0;
	localparam int ST_SLEEP = 1;
	localparam int ST_CARRY = 2;
	localparam int ST_DCARRY = 3;
	localparam int ST_ZERO   = 4;
	localparam int ST_TO     = 5;
	localparam int ST_PDOWN  = 6;

	// reset values
	localparam logic RST_TIME_OUT   = 1'b1;
	localparam logic RST_POWER_DOWN = 1'b1;
	localparam logic RST_FLAG       = 1'b0;

	// opcode encodings and fields
	localparam logic [OPC_W-1:0] OPC_RETURN = 14'h0008;
	localparam logic [OPC_W-1:0] OPC_SLEEP  = 14'h0063;
	localparam logic [3:0]       OPC_LITRET_HI4 = 4'hD;
	localparam logic [4:0]       OPC_SUBLIT_HI5 = 5'h1E;
	localparam logic [5:0]       OPC_ROTL_HI6   = 6'h0D;
	localparam logic [5:0]       OPC_ROTR_HI6   = 6'h0C;
	localparam int               DEST_BIT       = 7;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_READ  = 4'b0010,
		S_EXEC  = 4'b0100,
		S_SLEEP = 4'b1000
	} exec_state_t;

endpackage : insn_exec_pkg

//--- rtl/file_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface file_mem_if #(
	parameter int AW = 7,
	parameter int DW = 8
);
	logic          en;
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport requester (output en, output we, output addr, output wdata, input rdata);
	modport memory    (input en, input we, input addr, input wdata, output rdata);
endinterface : file_mem_if
`default_nettype wire

//--- rtl/file_regfile.sv
`timescale 1ns/10ps
`default_nettype none
module file_regfile #(
	parameter int DEPTH = 128,
	parameter int AW    = 7,
	parameter int DW    = 8
) (
	input  wire logic    clk,
	input  wire logic    rst_n,
	file_mem_if.memory   port
);
	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
		$error("file_regfile: depth does not fit the address width");
	end

	logic [DW-1:0] cells [DEPTH];

	// storage has no reset, so software must preload before relying on contents
	always_ff @(posedge clk) begin
		if (port.en && port.we) begin
			cells[port.addr] <= port.wdata;
		end
	end

	// read data registered, valid the cycle after the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port.rdata <= '0;
		end else if (port.en && !port.we) begin
			port.rdata <= cells[port.addr];
		end
	end
endmodule : file_regfile
`default_nettype wire

//--- rtl/cpu_insn_exec_subset.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_insn_exec_subset
	import insn_exec_pkg::*;
#(
	parameter int PC_W            = PC_WIDTH,
	parameter int INSN_CYCLE_CLKS = INSN_CYCLE_CLKS_DFLT
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic [PC_W-1:0]   stack_top_entry,
	output logic                   stack_pop,
	output logic [PC_W-1:0]        program_counter,
	output logic [DATA_W-1:0]      accumulator,
	output logic                   watchdog_clear,
	output logic                   cpu_halted,
	output logic                   osc_stop,
	input  wire logic              wake_request
);
	if (INSN_CYCLE_CLKS < 1 || INSN_CYCLE_CLKS > 256 || PC_W < 1 || PC_W > 32) begin : g_bad_param
		$error("cpu_insn_exec_subset: unsupported parameter value");
	end

	typedef struct packed {
		exec_state_t        st;
		logic [OPC_W-1:0]   opcode;
		logic [DATA_W-1:0]  operand;
		logic [DATA_W-1:0]  acc;
		logic               carry;
		logic               digit_carry_flag;
		logic               zero;
		logic               time_out_flag;
		logic               power_down_flag;
		logic [PC_W-1:0]    pc;
		logic [7:0]         div;
		logic [1:0]         ticks;
		logic [FILE_AW-1:0] faddr;
		logic [1:0]         rd_pend;
		logic [31:0]        rdata;
		logic               pop;
		logic               wdt_clr;
		logic               wake_s0;
		logic               wake_s1;
	} core_state_t;

	localparam core_state_t STATE_RST = '{st: S_IDLE, time_out_flag: RST_TIME_OUT,
		power_down_flag: RST_POWER_DOWN, carry: RST_FLAG, digit_carry_flag: RST_FLAG,
		zero: RST_FLAG, default: '0};

	core_state_t s;
	core_state_t next_s;

	file_mem_if #(.AW(FILE_AW), .DW(DATA_W)) mif ();

	file_regfile #(.DEPTH(FILE_DEPTH), .AW(FILE_AW), .DW(DATA_W)) u_regfile (
		.clk   (pclk),
		.rst_n (presetn),
		.port  (mif.memory)
	);

	// opcode decode: op_is_rot serves the start path, the assigns below serve the execute path
	function automatic logic op_is_rot(input logic [OPC_W-1:0] op);
		op_is_rot = (op[OPC_W-1 -: 6] == OPC_ROTL_HI6) || (op[OPC_W-1 -: 6] == OPC_ROTR_HI6);
	endfunction : op_is_rot

	logic                 op_litret;
	logic                 op_return;
	logic                 op_rotl;
	logic                 op_rotr;
	logic                 op_sub;
	logic                 op_sleep;
	logic                 dest_file;
	logic [DATA_W-1:0]    lit;
	logic [DATA_W:0]      sub_full;
	logic [4:0]           sub_nib;
	logic [1:0]           needed;
	logic                 tick;
	logic                 commit;
	logic                 busy;
	logic                 access;
	logic                 mapped;
	logic [31:0]          read_mux;
	logic [DATA_W-1:0]    rot_res;

	assign op_litret = s.opcode[OPC_W-1 -: 4] == OPC_LITRET_HI4;
	assign op_return = s.opcode == OPC_RETURN;
	assign op_rotl   = s.opcode[OPC_W-1 -: 6] == OPC_ROTL_HI6;
	assign op_rotr   = s.opcode[OPC_W-1 -: 6] == OPC_ROTR_HI6;
	assign op_sub    = s.opcode[OPC_W-1 -: 5] == OPC_SUBLIT_HI5;
	assign op_sleep  = s.opcode == OPC_SLEEP;
	assign dest_file = s.opcode[DEST_BIT];
	assign lit       = s.opcode[DATA_W-1:0];

	// borrow-free sense: add the inverted accumulator plus one
	assign sub_full = {1'b0, lit} + {1'b0, ~s.acc} + 9'h001;
	assign sub_nib  = {1'b0, lit[3:0]} + {1'b0, ~s.acc[3:0]} + 5'h01;

	// nine-bit rotate through carry
	assign rot_res = op_rotl ? {s.operand[DATA_W-2:0], s.carry} : {s.carry, s.operand[DATA_W-1:1]};

	// both returns take two instruction cycles, the rest one
	assign needed = (op_litret || op_return) ? CYCLES_RET : CYCLES_ONE;
	assign tick   = s.div == 8'(INSN_CYCLE_CLKS - 1);
	assign commit = (s.st == S_EXEC) && tick && (s.ticks == 2'(needed - 2'h1));
	assign busy   = (s.st == S_READ) || (s.st == S_EXEC);
	assign access = psel && penable;

	// address decode and register read view
	always_comb begin
		read_mux = 32'h0;
		mapped   = 1'b1;
		if (paddr == ADDR_STATUS) begin
			read_mux[ST_BUSY]  = busy;
			read_mux[ST_SLEEP] = s.st == S_SLEEP;
			read_mux[ST_CARRY] = s.carry;
			read_mux[ST_DCARRY] = s.digit_carry_flag;
			read_mux[ST_ZERO]  = s.zero;
			read_mux[ST_TO]    = s.time_out_flag;
			read_mux[ST_PDOWN] = s.power_down_flag;
		end else if (paddr == ADDR_ACC) begin
			read_mux = 32'(s.acc);
		end else if (paddr == ADDR_PC) begin
			read_mux = 32'(s.pc);
		end else if (paddr == ADDR_FILE_ADDR) begin
			read_mux = 32'(s.faddr);
		end else if (paddr != ADDR_INSN && paddr != ADDR_FILE_DATA) begin
			mapped = 1'b0;
		end
	end

	// writes and file reads wait while an instruction runs; other reads never wait
	always_comb begin
		if (pwrite) begin
			pready = !busy;
		end else if (paddr == ADDR_FILE_DATA) begin
			pready = s.rd_pend == 2'h2;
		end else begin
			pready = 1'b1;
		end
	end

	assign pslverr = access && pready && !mapped;
	assign prdata  = s.rdata;

	// next-state logic: bus side first, execution last so it wins on the memory port
	always_comb begin
		next_s         = s;
		next_s.pop     = 1'b0;
		next_s.wdt_clr = 1'b0;
		next_s.wake_s0 = wake_request;
		next_s.wake_s1 = s.wake_s0;
		mif.en         = 1'b0;
		mif.we         = 1'b0;
		mif.addr       = s.faddr;
		mif.wdata      = pwdata[DATA_W-1:0];

		// snapshot plain reads in the setup cycle so prdata comes from a flop
		if (psel && !penable && !pwrite) begin
			next_s.rdata = read_mux;
		end
		if (access && !pwrite && paddr == ADDR_FILE_DATA) begin
			unique case (s.rd_pend)
				2'h0: if (!busy) begin
					mif.en         = 1'b1;
					next_s.rd_pend = 2'h1;
				end
				2'h1: begin
					next_s.rdata   = 32'(mif.rdata);
					next_s.rd_pend = 2'h2;
				end
				default: next_s.rd_pend = 2'h0;
			endcase
		end
		if (access && pwrite && !busy) begin
			if (paddr == ADDR_INSN && s.st == S_IDLE) begin
				// instruction writes during sleep are dropped
				next_s.opcode = pwdata[OPC_W-1:0];
				next_s.div    = 8'h00;
				next_s.ticks  = 2'h0;
				if (op_is_rot(pwdata[OPC_W-1:0])) begin
					mif.en    = 1'b1;
					mif.addr  = pwdata[FILE_AW-1:0];
					next_s.st = S_READ;
				end else begin
					next_s.st = S_EXEC;
				end
			end else if (paddr == ADDR_STATUS) begin
				next_s.carry            = pwdata[ST_CARRY];
				next_s.digit_carry_flag = pwdata[ST_DCARRY];
				next_s.zero             = pwdata[ST_ZERO];
			end else if (paddr == ADDR_ACC) begin
				next_s.acc = pwdata[DATA_W-1:0];
			end else if (paddr == ADDR_FILE_ADDR) begin
				next_s.faddr = pwdata[FILE_AW-1:0];
			end else if (paddr == ADDR_FILE_DATA) begin
				mif.en = 1'b1;
				mif.we = 1'b1;
			end
		end

		unique case (s.st)
			S_IDLE: begin
			end
			S_READ: begin
				next_s.operand = mif.rdata;
				next_s.st      = S_EXEC;
			end
			S_EXEC: begin
				next_s.div = tick ? 8'h00 : s.div + 8'h01;
				if (tick) begin
					next_s.ticks = s.ticks + 2'h1;
				end
				if (commit) begin
					next_s.st = S_IDLE;
					next_s.pc = s.pc + 1'b1;
					if (op_litret || op_return) begin
						next_s.pc  = stack_top_entry;
						next_s.pop = 1'b1;
						if (op_litret) begin
							next_s.acc = lit;
						end
					end else if (op_rotl || op_rotr) begin
						next_s.carry = op_rotl ? s.operand[DATA_W-1] : s.operand[0];
						if (dest_file) begin
							mif.en    = 1'b1;
							mif.we    = 1'b1;
							mif.addr  = s.opcode[FILE_AW-1:0];
							mif.wdata = rot_res;
						end else begin
							next_s.acc = rot_res;
						end
					end else if (op_sub) begin
						next_s.acc              = sub_full[DATA_W-1:0];
						next_s.carry            = sub_full[DATA_W];
						next_s.digit_carry_flag = sub_nib[4];
						next_s.zero             = sub_full[DATA_W-1:0] == 8'h00;
					end else if (op_sleep) begin
						next_s.power_down_flag = 1'b0;
						next_s.time_out_flag   = 1'b1;
						next_s.wdt_clr         = 1'b1;
						next_s.st              = S_SLEEP;
					end
				end
			end
			S_SLEEP: if (s.wake_s1) begin
				next_s.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign stack_pop       = s.pop;
	assign program_counter = s.pc;
	assign accumulator     = s.acc;
	assign watchdog_clear  = s.wdt_clr;
	// core and oscillator both held for the whole sleep
	assign cpu_halted      = s.st == S_SLEEP;
	assign osc_stop        = s.st == S_SLEEP;

	// cycles spent in the execute state, read only by the checks below
	logic [9:0] exec_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_cnt <= 10'h000;
		end else begin
			exec_cnt <= (s.st == S_EXEC) ? exec_cnt + 10'h001 : 10'h000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_litret_effect: assert property ((commit && op_litret) |=>
		(s.acc == $past(lit)) && (s.pc == $past(stack_top_entry)) && stack_pop)
		else $error("literal return did not load accumulator and pc");
	chk_return_flags: assert property ((commit && (op_litret || op_return)) |=>
		(s.carry == $past(s.carry)) && (s.zero == $past(s.zero)) && (s.digit_carry_flag == $past(s.digit_carry_flag)))
		else $error("return changed a status flag");
	chk_return_length: assert property ((commit && (op_litret || op_return)) |->
		exec_cnt == 10'(2 * INSN_CYCLE_CLKS - 1))
		else $error("return did not take two instruction cycles");
	chk_rotl_acc: assert property ((commit && op_rotl && !dest_file) |=>
		(s.acc == {$past(s.operand[6:0]), $past(s.carry)}) && (s.carry == $past(s.operand[7])))
		else $error("left rotate result wrong");
	chk_rotr_acc: assert property ((commit && op_rotr && !dest_file) |=>
		(s.acc == {$past(s.carry), $past(s.operand[7:1])}) && (s.carry == $past(s.operand[0])))
		else $error("right rotate result wrong");
	chk_rot_dest_file: assert property ((commit && (op_rotl || op_rotr) && dest_file) |->
		(mif.we && mif.addr == s.opcode[FILE_AW-1:0]) ##1 (s.acc == $past(s.acc)))
		else $error("rotate to file register misdirected");
	chk_rot_flags: assert property ((commit && (op_rotl || op_rotr)) |=>
		(s.zero == $past(s.zero)) && (s.digit_carry_flag == $past(s.digit_carry_flag)))
		else $error("rotate changed a flag other than carry");
	chk_sleep_entry: assert property ((commit && op_sleep) |=>
		!s.power_down_flag && s.time_out_flag && watchdog_clear && cpu_halted && osc_stop)
		else $error("sleep entry effects missing");
	chk_sleep_hold: assert property ((cpu_halted && !s.wake_s1) |=> cpu_halted)
		else $error("left sleep without a wake");
	chk_sub_result: assert property ((commit && op_sub) |=>
		(s.acc == ($past(lit) - $past(s.acc))) && (s.carry == ($past(lit) >= $past(s.acc))) && (s.zero == (s.acc == 8'h00)))
		else $error("literal subtract result or flags wrong");
	chk_sub_digit: assert property ((commit && op_sub) |=>
		s.digit_carry_flag == ($past(lit[3:0]) >= $past(s.acc[3:0])))
		else $error("digit carry wrong after subtract");

	cov_litret: cover property (commit && op_litret);
	cov_sleep_wake: cover property (cpu_halted ##1 (cpu_halted && s.wake_s1) ##1 !cpu_halted);
	cov_rotl_file: cover property (commit && op_rotl && dest_file);
	cov_sub_borrow: cover property (commit && op_sub && !sub_full[DATA_W]);
endmodule : cpu_insn_exec_subset
`default_nettype wire

//--- verification/stack_model.sv
`timescale 1ns/10ps
`default_nettype none
module stack_model
	import insn_exec_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           stack_pop,
	output logic [PC_WIDTH-1:0] stack_top_entry
);
	logic [1:0] depth_ptr;

	// each pop exposes the next entry; wraps after four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			depth_ptr <= 2'h0;
		else if (stack_pop)
			depth_ptr <= depth_ptr + 2'h1;
	end

	// distinct entries so a stale top entry cannot pass for a fresh one
	assign stack_top_entry = {depth_ptr, 11'h5A3} ^ 13'h00F0;
endmodule : stack_model
`default_nettype wire

//--- verification/cpu_insn_exec_subset_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_insn_exec_subset_tb_top
	import insn_exec_pkg::*;
;
	localparam int C = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic stack_pop, wdc, halt, osc, wake;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [PC_WIDTH-1:0] ste, pc, top;
	logic [DATA_W-1:0] acc;
	int cyc, t_taken, te, pop_cyc, wdc_cyc, fails, n_compared;

	cpu_insn_exec_subset #(.INSN_CYCLE_CLKS(C)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .stack_top_entry(ste), .stack_pop(stack_pop),
		.program_counter(pc), .accumulator(acc), .watchdog_clear(wdc), .cpu_halted(halt),
		.osc_stop(osc), .wake_request(wake));
	stack_model stack (.pclk(pclk), .presetn(presetn), .stack_pop(stack_pop), .stack_top_entry(ste));

	// clock at 5 ns
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// cycle stamps of the one-cycle pulses
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (stack_pop === 1'b1) pop_cyc <= cyc;
		if (wdc === 1'b1) wdc_cyc <= cyc;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) chk(32'h1, 32'h0, "apb hang");
		q = prdata; err = pslverr; t_taken = cyc;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// launch one opcode and wait for busy to drop
	task automatic exec(input logic [OPC_W-1:0] opc);
		apb(1'b1, ADDR_INSN, {18'h0, opc});
		te = t_taken;
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			if (q[ST_BUSY] === 1'b0) break;
		end
	endtask : exec

	task automatic t_reset;
		apb(1'b0, ADDR_STATUS, 32'h0); chk(q, 32'h60, "status reset");
		apb(1'b0, ADDR_PC, 32'h0); chk(q, 32'h0, "pc reset");
		apb(1'b0, 12'hFFC, 32'h0); chk({31'h0, err}, 32'h1, "unmapped error");
	endtask : t_reset

	task automatic t_sub;
		logic [7:0] k, w;
		logic [7:0] ks[4] = '{8'h05, 8'h02, 8'h10, 8'hFF};
		logic [7:0] ws[4] = '{8'h05, 8'h03, 8'h01, 8'h00};
		for (int i = 0; i < 4; i++) begin
			k = ks[i]; w = ws[i];
			apb(1'b1, ADDR_ACC, {24'h0, w});
			exec({OPC_SUBLIT_HI5, 1'b0, k});
			apb(1'b0, ADDR_ACC, 32'h0); chk(q, {24'h0, k - w}, "sub result");
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk(q[6:2], {2'b11, k[7:0] == w, k[3:0] >= w[3:0], k >= w}, "sub flags");
		end
	endtask : t_sub

	// both directions, both destinations, both carry values, edge addresses
	task automatic t_rot;
		logic l, d, c;
		logic [6:0] f;
		logic [7:0] v, r;
		for (int i = 0; i < 8; i++) begin
			l = i[0]; d = i[1]; c = i[2];
			f = l ? 7'h7F : 7'h00;
			v = 8'h96 ^ {8{i[0] ^ i[2]}};
			r = l ? {v[6:0], c} : {c, v[7:1]};
			apb(1'b1, ADDR_FILE_ADDR, {25'h0, f});
			apb(1'b1, ADDR_FILE_DATA, {24'h0, v});
			apb(1'b1, ADDR_ACC, 32'h3C);
			apb(1'b1, ADDR_STATUS, {27'h0, 2'b11, c, 2'h0});
			exec({l ? OPC_ROTL_HI6 : OPC_ROTR_HI6, d, f});
			apb(1'b0, ADDR_ACC, 32'h0); chk(q, {24'h0, d ? 8'h3C : r}, "rotate acc");
			apb(1'b0, ADDR_FILE_DATA, 32'h0); chk(q, {24'h0, d ? r : v}, "rotate file");
			apb(1'b0, ADDR_STATUS, 32'h0); chk(q[4:2], {2'b11, l ? v[7] : v[0]}, "rotate carry");
		end
	endtask : t_rot

	task automatic t_ret;
		apb(1'b1, ADDR_STATUS, 32'h14);
		apb(1'b1, ADDR_ACC, 32'h11);
		top = ste;
		exec({OPC_LITRET_HI4, 2'b00, 8'hC7});
		chk(pop_cyc - te, 2 * C + 1, "literal return time");
		chk({19'h0, pc}, {19'h0, top}, "literal return pc");
		apb(1'b0, ADDR_ACC, 32'h0); chk(q, 32'hC7, "literal return acc");
		apb(1'b0, ADDR_STATUS, 32'h0); chk(q[4:2], 3'b101, "literal return flags");
		top = ste;
		exec(OPC_RETURN);
		chk(pop_cyc - te, 2 * C + 1, "return time");
		chk({19'h0, pc}, {19'h0, top}, "return pc");
		apb(1'b0, ADDR_STATUS, 32'h0); chk(q[4:2], 3'b101, "return flags");
	endtask : t_ret

	task automatic t_sleep;
		exec(OPC_SLEEP);
		chk(wdc_cyc - te, C + 1, "watchdog clear");
		chk({halt, osc}, 2'b11, "halted");
		chk(q[6:5], 2'b01, "sleep flags");
		apb(1'b1, ADDR_INSN, {18'h0, OPC_SUBLIT_HI5, 9'h000});
		apb(1'b0, ADDR_ACC, 32'h0); chk(q, 32'hC7, "insn dropped asleep");
		wake <= 1'b1;
		for (int i = 0; i < 20 && halt !== 1'b0; i++) @(posedge pclk);
		chk({31'h0, halt}, 32'h0, "wake");
		wake <= 1'b0;
	endtask : t_sleep

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// cut a hang short well after all scenarios should be done
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		print_verdict();
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; wake = 1'b0;
		cyc = 0; fails = 0; n_compared = 0; pop_cyc = 0; wdc_cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sub();
		t_rot();
		t_ret();
		t_sleep();
		print_verdict();
	end
endmodule : cpu_insn_exec_subset_tb_top
`default_nettype wire
